//--- design/rpr_pkg.sv
// Package for the registered PROM read path.
// Assumes a single core clock; shared by the design and its bench.
package rpr_pkg;
    localparam int unsigned WORD_COUNT = 512;
    localparam int unsigned ADDR_W     = 9;
    localparam int unsigned DATA_W     = 8;
    // Unprogrammed fuses read low
    localparam logic [7:0]  BLANK_WORD = 8'h00;
    localparam logic        SYNC_OFF   = 1'b1;

    typedef struct packed {
        logic [8:0] word_select;
        logic       sync_output_enable_n;
        logic       init_n;
    } rpr_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] data_oe_n;
    } rpr_out_t;
endpackage : rpr_pkg

//--- design/rpr_prom.sv
// Registered 512 x 8 one-time-programmable read path with init word and enables.
// Assumes host pins arrive asynchronously and pass two flip-flops here; i_rst models power-up.
//
// Contract
// - The array holds 512 words of 8 bits, chosen by a 9-bit word select.
// - Ahead of the clock edge the addressed word feeds the master stage.
// - Each rising edge moves the master word into both the slave and the output register, which drives the outputs.
// - After an edge the inputs may change while the output word stays until the next edge.
// - A synchronous enable sampled high at an edge turns the outputs off from that edge.
// - A high asynchronous enable, once through the two flip-flops and the output register, holds the outputs off regardless of sync enable.
// - Outputs drive only with sync enable sampled low and async enable low.
// - At power-up the sync enable flip-flop starts in the off state.
// - A low on init selects one extra programmable 8-bit word instead of the array.
// - The init word enters the output register only at the next rising edge.
// - An unprogrammed init word reads as all zeros, clearing the output register.
// - Array bits read zero until programmed; a programmed bit stays one for good.
`timescale 1ns/1ps
module rpr_prom #(
    parameter logic [7:0] INIT_WORD = rpr_pkg::BLANK_WORD
) (
    input  wire logic                i_core_clk,
    input  wire logic                i_rst,
    input  wire rpr_pkg::rpr_req_t   i_req,
    input  wire logic                i_async_output_enable_n,
    // Programming port: OR-in ones at the selected word, never clears
    input  wire logic                i_prog_en,
    input  wire logic [8:0]          i_prog_addr,
    input  wire logic [7:0]          i_prog_data,
    output rpr_pkg::rpr_out_t        o_q
);
    rpr_pkg::rpr_req_t req_meta;
    rpr_pkg::rpr_req_t req_sync;
    logic              g_meta;
    logic              g_sync;
    logic              prog_meta;
    logic              prog_sync;
    logic [8:0]        paddr_meta;
    logic [8:0]        paddr_sync;
    logic [7:0]        pdata_meta;
    logic [7:0]        pdata_sync;
    // Fuses survive reset: they model nonvolatile storage and start blank
    logic [7:0]        fuse [rpr_pkg::WORD_COUNT] = '{default: rpr_pkg::BLANK_WORD};
    logic [7:0]        master;
    logic [7:0]        next_master;
    logic [7:0]        slave;
    logic              sync_off;

    // Two flip-flops on every pin; the array never sees a half-settled address
    always_ff @(posedge i_core_clk) begin
        req_meta <= i_req;
        req_sync <= req_meta;
    end

    // The off control is synchronised too, so it lags the pin by the chain
    always_ff @(posedge i_core_clk) begin
        g_meta <= i_async_output_enable_n;
        g_sync <= g_meta;
    end

    // Address and data must hold for the chain plus one edge while the strobe stands;
    // the bus is not gray coded, so a moving address could burn the wrong word
    always_ff @(posedge i_core_clk) begin
        prog_meta  <= i_prog_en;
        prog_sync  <= prog_meta;
        paddr_meta <= i_prog_addr;
        paddr_sync <= paddr_meta;
        pdata_meta <= i_prog_data;
        pdata_sync <= pdata_meta;
    end

    // Either enable high turns every data bit off; the bits never differ
    function automatic logic [7:0] off_mask(input logic sen_n, input logic async_off);
        logic [7:0] mask;
        mask = {rpr_pkg::DATA_W{sen_n | async_off}};
        return mask;
    endfunction : off_mask

    // The init request overrides whatever word the address picks
    function automatic logic [7:0] pick_word(input logic init_n, input logic [7:0] stored);
        logic [7:0] word;
        if (!init_n) begin
            word = INIT_WORD;
        end else begin
            word = stored;
        end
        return word;
    endfunction : pick_word

    // Programming only ORs ones in, so a bit once set can never fall back
    always_ff @(posedge i_core_clk) begin
        if (prog_sync) begin
            fuse[paddr_sync] <= fuse[paddr_sync] | pdata_sync;
        end
    end

    // Master stage is transparent to the array ahead of the edge
    always_comb begin
        next_master = pick_word(req_sync.init_n, fuse[req_sync.word_select]);
    end
    assign master = next_master;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            slave <= rpr_pkg::BLANK_WORD;
        end else begin
            slave <= master;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sync_off <= rpr_pkg::SYNC_OFF;
        end else begin
            sync_off <= req_sync.sync_output_enable_n;
        end
    end

    // Output enable registered from the next-state so it lines up with the slave word;
    // the async path therefore lags the pin by the synchroniser plus one edge.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_q.data      <= rpr_pkg::BLANK_WORD;
            o_q.data_oe_n <= '1;
        end else begin
            o_q.data      <= master;
            o_q.data_oe_n <= off_mask(req_sync.sync_output_enable_n, g_sync);
        end
    end

    a_init_loads: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !req_sync.init_n |=> slave == INIT_WORD)
        else $error("init word not loaded");
    a_sync_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
        req_sync.sync_output_enable_n |=> sync_off && o_q.data_oe_n == 8'hff)
        else $error("sync enable high did not turn outputs off");
    a_async_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
        g_sync |=> o_q.data_oe_n == 8'hff)
        else $error("async enable high did not hold outputs off");
    a_drive_only: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_q.data_oe_n != 8'hff |-> !$past(req_sync.sync_output_enable_n) && !$past(g_sync))
        else $error("outputs driven without both enables low");
    a_data_track: assert property (@(posedge i_core_clk) disable iff (i_rst)
        1'b1 |=> o_q.data == slave)
        else $error("output word differs from slave stage");
    a_array_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
        req_sync.init_n && !prog_sync |=> slave == $past(fuse[req_sync.word_select]))
        else $error("slave did not capture addressed word");
    a_stable_word: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ##1 $stable(slave) || (slave == $past(master)))
        else $error("output word changed between edges");
    a_fuse_sticky: assert property (@(posedge i_core_clk)
        prog_sync |=> (fuse[$past(paddr_sync)] & $past(pdata_sync)) == $past(pdata_sync))
        else $error("programmed bit not set");
    a_reset_off: assert property (@(posedge i_core_clk)
        i_rst |=> sync_off && o_q.data_oe_n == 8'hff)
        else $error("outputs not off after power-up");

    // Enable checks: both low drives, either high turns all bits off; last, the power-up data clear
    a_drive_on: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !req_sync.sync_output_enable_n && !g_sync |=> o_q.data_oe_n == 8'h00)
        else $error("outputs not driven with both enables low");

    a_oe_uniform: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_q.data_oe_n == 8'h00 || o_q.data_oe_n == 8'hff)
        else $error("output enable bits disagree");

    a_async_wins: assert property (@(posedge i_core_clk) disable iff (i_rst)
        g_sync && !req_sync.sync_output_enable_n |=> o_q.data_oe_n == 8'hff)
        else $error("async enable did not override sync enable");

    a_sync_edge: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(req_sync.sync_output_enable_n) |=> o_q.data_oe_n == 8'hff)
        else $error("outputs still on after sync enable rose");

    a_flop_matches: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_q.data_oe_n != 8'hff |-> !sync_off)
        else $error("outputs driven while sync flip-flop is off");

    a_mask_match: assert property (@(posedge i_core_clk) disable iff (i_rst)
        1'b1 |=> o_q.data_oe_n
            == off_mask($past(req_sync.sync_output_enable_n), $past(g_sync)))
        else $error("output enable does not follow sampled enables");

    a_reset_data: assert property (@(posedge i_core_clk)
        i_rst |=> o_q.data == rpr_pkg::BLANK_WORD)
        else $error("output word not cleared at power-up");

    // Word checks: array read, init override and output hold
    a_array_out: assert property (@(posedge i_core_clk) disable iff (i_rst)
        req_sync.init_n |=> o_q.data == $past(fuse[req_sync.word_select]))
        else $error("output word differs from addressed array word");

    a_drive_data: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !req_sync.sync_output_enable_n && !g_sync && req_sync.init_n
        |=> o_q.data_oe_n == 8'h00 && o_q.data == $past(fuse[req_sync.word_select]))
        else $error("enabled read did not drive the addressed word");

    a_init_ignores: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !req_sync.init_n |=> o_q.data == INIT_WORD)
        else $error("address not ignored while init is low");

    a_init_edge: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $fell(req_sync.init_n) |=> slave == INIT_WORD)
        else $error("init word missed the next edge");

    a_init_blank: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !req_sync.init_n && INIT_WORD == rpr_pkg::BLANK_WORD |=> o_q.data == 8'h00)
        else $error("blank init word did not clear the output");

    a_hold_word: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $changed(req_sync.word_select) |=> o_q.data == $past(master))
        else $error("output word not the one captured at the edge");

    // Fuse checks: bits only ever gain ones, and only under the strobe
    a_bits_never_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
        1'b1 |=> (fuse[$past(paddr_sync)] & $past(fuse[paddr_sync]))
            == $past(fuse[paddr_sync]))
        else $error("a programmed bit returned to zero");

    a_prog_idle: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !prog_sync |=> fuse[$past(paddr_sync)] == $past(fuse[paddr_sync]))
        else $error("fuse word changed without a programming strobe");
endmodule : rpr_prom

//--- verif/rpr_host.sv
// Host-side model that packs the sequencer's request fields.
// Assumes the bench moves the fields just after a falling clock edge.
`timescale 1ns/1ps
module rpr_host (
    input  wire logic [8:0]   i_word_select,
    input  wire logic         i_sen_n,
    input  wire logic         i_init_n,
    output rpr_pkg::rpr_req_t o_req
);
    // Fields only change away from the rising edge that takes them
    assign o_req = {i_word_select, i_sen_n, i_init_n};
endmodule : rpr_host

//--- verif/registered_prom_read_path_tb_top.sv
// Self-checking bench for the registered PROM read path.
// Assumes three rising edges from a request to its registered answer.
`timescale 1ns/1ps
module registered_prom_read_path_tb_top;
    logic              i_core_clk = 1'b0;
    logic              i_rst      = 1'b1;
    logic [8:0]        word_sel   = 9'h000;
    logic              sen_n      = 1'b1;
    logic              init_n     = 1'b1;
    logic              async_n    = 1'b0;
    logic              prog_en    = 1'b0;
    logic [8:0]        prog_addr  = 9'h000;
    logic [7:0]        prog_data  = 8'h00;
    int                mismatches = 0;
    int                checks_done = 0;
    rpr_pkg::rpr_req_t req;
    rpr_pkg::rpr_out_t q;

    always #25 i_core_clk = ~i_core_clk;

    rpr_host host (.i_word_select(word_sel), .i_sen_n(sen_n), .i_init_n(init_n), .o_req(req));
    rpr_prom dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_req(req),
        .i_async_output_enable_n(async_n), .i_prog_en(prog_en), .i_prog_addr(prog_addr),
        .i_prog_data(prog_data), .o_q(q));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out

    // Fuses only gain ones; held four cycles to clear the input synchronisers
    task automatic burn(input logic [8:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        {prog_en, prog_addr, prog_data} <= {1'b1, a, d};
        repeat (4) @(negedge i_core_clk);
        prog_en <= 1'b0;
    endtask : burn

    // ctl is {sync enable_n, init_n, async off}; m masks data when outputs are off
    task automatic read(input logic [8:0] a, input logic [2:0] ctl, input logic [15:0] m,
                        input logic [15:0] exp);
        @(negedge i_core_clk);
        {word_sel, sen_n, init_n, async_n} <= {a, ctl};
        repeat (3) @(posedge i_core_clk);
        @(negedge i_core_clk);
        check(q & m, exp);
        $display("read test done at %0t", $time);
    endtask : read

    initial begin
        repeat (2000) @(posedge i_core_clk);
        mismatches++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge i_core_clk);
        @(negedge i_core_clk);
        check(q, 16'h00ff);
        i_rst <= 1'b0;
        $display("reset test done");
        burn(9'h005, 8'ha5);
        burn(9'h005, 8'h0a);
        read(9'h005, 3'b010, 16'hffff, 16'haf00);
        read(9'h1ff, 3'b010, 16'hffff, 16'h0000);
        read(9'h005, 3'b000, 16'hffff, 16'h0000);
        read(9'h005, 3'b110, 16'h00ff, 16'h00ff);
        read(9'h005, 3'b011, 16'h00ff, 16'h00ff);
        read(9'h005, 3'b010, 16'hffff, 16'haf00);
        close_out();
    end
endmodule : registered_prom_read_path_tb_top
